// [design/crf_pkg.sv]
// Package for the core register file: widths, flag positions, reset values and carriers.
// Assumes the decoder and datapath on the same clock use these types directly.
package crf_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned NUM_PAIRS = 8;
  localparam int unsigned SEL_W = 3;
  // Flag positions in the condition code register.
  localparam int unsigned POS_MASK = 7;
  localparam int unsigned POS_USER_HI = 6;
  localparam int unsigned POS_HALF = 5;
  localparam int unsigned POS_USER_LO = 4;
  localparam int unsigned POS_NEG = 3;
  localparam int unsigned POS_ZERO = 2;
  localparam int unsigned POS_OVF = 1;
  localparam int unsigned POS_CARRY = 0;
  // Index of the pair that serves as stack pointer.
  localparam logic [2:0] STACK_PAIR_IDX = 3'h7;
  // Reset vector address and the condition code value after reset.
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
  localparam logic [7:0] CC_RESET = 8'h80;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Register write width selection.
  typedef enum logic [1:0] {
    CRF_WR_NONE = 2'b00,
    CRF_WR_WORD = 2'b01,
    CRF_WR_HIGH = 2'b10,
    CRF_WR_LOW = 2'b11
  } crf_wr_t;

  // Condition code operations issued by the decoder.
  typedef enum logic [2:0] {
    CRF_CC_NONE = 3'b000,
    CRF_CC_LOAD = 3'b001,
    CRF_CC_AND = 3'b010,
    CRF_CC_OR = 3'b011,
    CRF_CC_XOR = 3'b100,
    CRF_CC_ALU = 3'b101,
    CRF_CC_EXC = 3'b110
  } crf_ccop_t;

  // Datapath operations whose flags this block computes.
  typedef enum logic [3:0] {
    CRF_ALU_ADD_B = 4'h0,
    CRF_ALU_ADDX_B = 4'h1,
    CRF_ALU_SUB_B = 4'h2,
    CRF_ALU_SUBX_B = 4'h3,
    CRF_ALU_CMP_B = 4'h4,
    CRF_ALU_NEG_B = 4'h5,
    CRF_ALU_ADD_W = 4'h6,
    CRF_ALU_SUB_W = 4'h7,
    CRF_ALU_CMP_W = 4'h8,
    CRF_ALU_LOGIC_B = 4'h9,
    CRF_ALU_DEC_ADD = 4'hA,
    CRF_ALU_DEC_SUB = 4'hB,
    CRF_ALU_BIT = 4'hC,
    CRF_ALU_SHIFT_B = 4'hD,
    CRF_ALU_MOVE_W = 4'hE
  } crf_alu_t;

  // Branch conditions evaluated from the four status flags.
  typedef enum logic [3:0] {
    CRF_BR_ALWAYS = 4'h0,
    CRF_BR_NEVER = 4'h1,
    CRF_BR_HI = 4'h2,
    CRF_BR_LS = 4'h3,
    CRF_BR_CC = 4'h4,
    CRF_BR_CS = 4'h5,
    CRF_BR_NE = 4'h6,
    CRF_BR_EQ = 4'h7,
    CRF_BR_VC = 4'h8,
    CRF_BR_VS = 4'h9,
    CRF_BR_PL = 4'hA,
    CRF_BR_MI = 4'hB,
    CRF_BR_GE = 4'hC,
    CRF_BR_LT = 4'hD,
    CRF_BR_GT = 4'hE,
    CRF_BR_LE = 4'hF
  } crf_br_t;

  // Register write request.
  typedef struct packed {
    crf_wr_t width;
    logic [2:0] pair;
    logic [15:0] data;
  } crf_wreq_t;

  // Arithmetic flag request: operands, result and update masks.
  typedef struct packed {
    crf_alu_t op;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] result;
    logic bit_value;
    logic [3:0] keep;
  } crf_areq_t;

  // Whole state of the register file.
  typedef struct packed {
    logic [7:0][15:0] pairs;
    logic [15:0] pc;
    logic [7:0] cc;
    logic [15:0] rd_word;
    logic [15:0] addr;
    logic [15:0] sp;
    logic [7:0] rd_byte;
    logic [7:0] cc_out;
    logic branch_taken;
  } crf_state_t;
endpackage

// [design/crf_core.sv]
// Programmer-visible register state of the core: general pairs, program counter, condition code.
// Assumes the decoder and datapath share the clock, issue at most one request of each kind
// per cycle, and use registered read results one cycle after the select is presented.

module crf_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] rd_pair,
  input wire logic rd_high,
  input wire logic [2:0] addr_pair,
  input wire crf_pkg::crf_wreq_t wreq,
  input wire logic sp_write,
  input wire logic [15:0] sp_data,
  input wire logic pc_load,
  input wire logic [15:0] pc_data,
  input wire logic vector_load,
  input wire logic [15:0] vector_data,
  input wire crf_pkg::crf_ccop_t cc_op,
  input wire logic [7:0] cc_data,
  input wire crf_pkg::crf_areq_t areq,
  input wire logic [2:0] bit_pos,
  input wire crf_pkg::crf_br_t br_cond,
  output logic [15:0] rd_word,
  output logic [7:0] rd_byte,
  output logic [15:0] addr_out,
  output logic [15:0] sp_out,
  output logic [15:0] pc_out,
  output logic [7:0] cc_out,
  output logic irq_masked,
  output logic branch_taken,
  output logic bit_sel,
  output logic [7:0] bcd_adjust,
  output logic [15:0] reset_fetch_addr
);
  crf_pkg::crf_state_t s;
  crf_pkg::crf_state_t next_s;
  logic [7:0] flags_new;
  logic [7:0] cc_after;
  logic [7:0] adj;
  logic half_in;
  logic sel_bit;
  logic bit_src;

  // Half carry is bit four (or twelve) of a xor b xor sum for add and subtract alike.
  function automatic logic half_of(input logic [15:0] a, input logic [15:0] b,
                                   input logic [15:0] r, input logic word);
    logic [15:0] x;
    x = a ^ b ^ r;
    half_of = word ? x[12] : x[4];
  endfunction

  // Branch evaluation from the four status flags; unused bits are ignored on purpose.
  function automatic logic branch_of(input crf_pkg::crf_br_t c, input logic [7:0] f);
    logic n;
    logic z;
    logic v;
    logic cy;
    n = f[crf_pkg::POS_NEG];
    z = f[crf_pkg::POS_ZERO];
    v = f[crf_pkg::POS_OVF];
    cy = f[crf_pkg::POS_CARRY];
    case (c)
      crf_pkg::CRF_BR_ALWAYS: branch_of = 1'b1;
      crf_pkg::CRF_BR_NEVER: branch_of = 1'b0;
      crf_pkg::CRF_BR_HI: branch_of = ~(cy | z);
      crf_pkg::CRF_BR_LS: branch_of = cy | z;
      crf_pkg::CRF_BR_CC: branch_of = ~cy;
      crf_pkg::CRF_BR_CS: branch_of = cy;
      crf_pkg::CRF_BR_NE: branch_of = ~z;
      crf_pkg::CRF_BR_EQ: branch_of = z;
      crf_pkg::CRF_BR_VC: branch_of = ~v;
      crf_pkg::CRF_BR_VS: branch_of = v;
      crf_pkg::CRF_BR_PL: branch_of = ~n;
      crf_pkg::CRF_BR_MI: branch_of = n;
      crf_pkg::CRF_BR_GE: branch_of = ~(n ^ v);
      crf_pkg::CRF_BR_LT: branch_of = n ^ v;
      crf_pkg::CRF_BR_GT: branch_of = ~(z | (n ^ v));
      default: branch_of = z | (n ^ v);
    endcase
  endfunction

  // Selected bit of the byte operand, registered onto bit_sel; the bit flag path takes bit_value instead.
  assign sel_bit = areq.a[bit_pos];
  assign half_in = s.cc[crf_pkg::POS_HALF];

  // Decimal adjust correction from the two digits of the byte and the carry flags.
  always_comb
  begin
    adj = crf_pkg::BYTE_ZERO;
    if (areq.op == crf_pkg::CRF_ALU_DEC_ADD)
    begin
      if (half_in || (areq.a[3:0] > 4'h9))
        adj[3:0] = 4'h6;
      if (s.cc[crf_pkg::POS_CARRY] || (areq.a[7:0] > 8'h99))
        adj[7:4] = 4'h6;
    end
    else if (areq.op == crf_pkg::CRF_ALU_DEC_SUB)
    begin
      if (half_in)
        adj[3:0] = 4'hA;
      if (s.cc[crf_pkg::POS_CARRY])
        adj[7:4] = half_in ? 4'h9 : 4'hA;
    end
  end

  // Flag computation; keep bits hold N, Z, V, C at their old values per instruction.
  always_comb
  begin
    logic word;
    logic msb_a;
    logic msb_b;
    logic msb_r;
    logic is_sub;
    word = 1'b0;
    msb_a = 1'b0;
    msb_b = 1'b0;
    msb_r = 1'b0;
    is_sub = 1'b0;
    bit_src = sel_bit;
    flags_new = s.cc;
    word = (areq.op == crf_pkg::CRF_ALU_ADD_W) || (areq.op == crf_pkg::CRF_ALU_SUB_W) ||
           (areq.op == crf_pkg::CRF_ALU_CMP_W) || (areq.op == crf_pkg::CRF_ALU_MOVE_W);
    msb_a = word ? areq.a[15] : areq.a[7];
    msb_b = word ? areq.b[15] : areq.b[7];
    msb_r = word ? areq.result[15] : areq.result[7];
    is_sub = (areq.op == crf_pkg::CRF_ALU_SUB_B) || (areq.op == crf_pkg::CRF_ALU_SUBX_B) ||
             (areq.op == crf_pkg::CRF_ALU_CMP_B) || (areq.op == crf_pkg::CRF_ALU_NEG_B) ||
             (areq.op == crf_pkg::CRF_ALU_SUB_W) || (areq.op == crf_pkg::CRF_ALU_CMP_W);
    flags_new[crf_pkg::POS_NEG] = msb_r;
    flags_new[crf_pkg::POS_ZERO] = word ? (areq.result == crf_pkg::WORD_ZERO) :
                                   (areq.result[7:0] == crf_pkg::BYTE_ZERO);
    flags_new[crf_pkg::POS_OVF] = 1'b0;
    case (areq.op)
      crf_pkg::CRF_ALU_ADD_B, crf_pkg::CRF_ALU_ADDX_B, crf_pkg::CRF_ALU_ADD_W:
      begin
        flags_new[crf_pkg::POS_HALF] = half_of(areq.a, areq.b, areq.result, word);
        flags_new[crf_pkg::POS_OVF] = (msb_a == msb_b) && (msb_r != msb_a);
        flags_new[crf_pkg::POS_CARRY] = (msb_a & msb_b) | ((msb_a | msb_b) & ~msb_r);
      end
      crf_pkg::CRF_ALU_SUB_B, crf_pkg::CRF_ALU_SUBX_B, crf_pkg::CRF_ALU_CMP_B,
      crf_pkg::CRF_ALU_NEG_B, crf_pkg::CRF_ALU_SUB_W, crf_pkg::CRF_ALU_CMP_W:
      begin
        // Negate is presented as zero minus b, with a held at zero.
        flags_new[crf_pkg::POS_HALF] = half_of(areq.a, areq.b, areq.result, word);
        flags_new[crf_pkg::POS_OVF] = is_sub && (msb_a != msb_b) && (msb_r != msb_a);
        flags_new[crf_pkg::POS_CARRY] = (~msb_a & msb_b) | ((~msb_a | msb_b) & msb_r);
      end
      crf_pkg::CRF_ALU_DEC_ADD, crf_pkg::CRF_ALU_DEC_SUB:
        flags_new[crf_pkg::POS_CARRY] = s.cc[crf_pkg::POS_CARRY] | (adj[7:4] != 4'h0);
      crf_pkg::CRF_ALU_BIT:
      begin
        // Bit operations only touch carry; the datapath picks the combining function.
        flags_new = s.cc;
        flags_new[crf_pkg::POS_CARRY] = areq.bit_value;
      end
      crf_pkg::CRF_ALU_SHIFT_B:
        flags_new[crf_pkg::POS_CARRY] = areq.bit_value;
      default:
        flags_new[crf_pkg::POS_CARRY] = s.cc[crf_pkg::POS_CARRY];
    endcase
    if (areq.keep[3])
      flags_new[crf_pkg::POS_NEG] = s.cc[crf_pkg::POS_NEG];
    if (areq.keep[2])
      flags_new[crf_pkg::POS_ZERO] = s.cc[crf_pkg::POS_ZERO];
    if (areq.keep[1])
      flags_new[crf_pkg::POS_OVF] = s.cc[crf_pkg::POS_OVF];
    if (areq.keep[0])
      flags_new[crf_pkg::POS_CARRY] = s.cc[crf_pkg::POS_CARRY];
    // User bits never change through arithmetic.
    flags_new[crf_pkg::POS_USER_HI] = s.cc[crf_pkg::POS_USER_HI];
    flags_new[crf_pkg::POS_USER_LO] = s.cc[crf_pkg::POS_USER_LO];
    flags_new[crf_pkg::POS_MASK] = s.cc[crf_pkg::POS_MASK];
  end

  // Condition code update; one operation per cycle, and exception entry only sets the mask bit.
  always_comb
  begin
    cc_after = s.cc;
    case (cc_op)
      crf_pkg::CRF_CC_LOAD: cc_after = cc_data;
      crf_pkg::CRF_CC_AND: cc_after = s.cc & cc_data;
      crf_pkg::CRF_CC_OR: cc_after = s.cc | cc_data;
      crf_pkg::CRF_CC_XOR: cc_after = s.cc ^ cc_data;
      crf_pkg::CRF_CC_ALU: cc_after = flags_new;
      crf_pkg::CRF_CC_EXC: cc_after[crf_pkg::POS_MASK] = 1'b1;
      default: cc_after = s.cc;
    endcase
  end

  // Next state of the state record: pairs, counter, condition code and the registered outputs it holds.
  always_comb
  begin
    next_s = s;
    case (wreq.width)
      crf_pkg::CRF_WR_WORD: next_s.pairs[wreq.pair] = wreq.data;
      crf_pkg::CRF_WR_HIGH: next_s.pairs[wreq.pair][15:8] = wreq.data[7:0];
      crf_pkg::CRF_WR_LOW: next_s.pairs[wreq.pair][7:0] = wreq.data[7:0];
      default: next_s.pairs = s.pairs;
    endcase
    // Implicit stack use overrides a general write to the same pair in one cycle.
    if (sp_write)
      next_s.pairs[crf_pkg::STACK_PAIR_IDX] = sp_data;
    if (vector_load)
      next_s.pc = {vector_data[15:1], 1'b0};
    else if (pc_load)
      next_s.pc = {pc_data[15:1], 1'b0};
    next_s.cc = cc_after;
    next_s.rd_word = s.pairs[rd_pair];
    next_s.rd_byte = rd_high ? s.pairs[rd_pair][15:8] : s.pairs[rd_pair][7:0];
    next_s.addr = s.pairs[addr_pair];
    next_s.sp = s.pairs[crf_pkg::STACK_PAIR_IDX];
    next_s.cc_out = s.cc;
    next_s.branch_taken = branch_of(br_cond, s.cc);
  end

  // Registers only; general pairs are left alone by reset so software must set them up.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s <= next_s;
      s.pc <= crf_pkg::RESET_VECTOR_ADDR;
      s.cc <= crf_pkg::CC_RESET;
      s.rd_word <= crf_pkg::WORD_ZERO;
      s.rd_byte <= crf_pkg::BYTE_ZERO;
      s.addr <= crf_pkg::WORD_ZERO;
      s.sp <= crf_pkg::WORD_ZERO;
      s.cc_out <= crf_pkg::CC_RESET;
      s.branch_taken <= 1'b0;
    end
    else
      s <= next_s;
  end

  // Plain outputs registered beside the state record.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bit_sel <= 1'b0;
      bcd_adjust <= crf_pkg::BYTE_ZERO;
      irq_masked <= 1'b1;
      reset_fetch_addr <= crf_pkg::RESET_VECTOR_ADDR;
    end
    else
    begin
      bit_sel <= bit_src;
      bcd_adjust <= adj;
      irq_masked <= cc_after[crf_pkg::POS_MASK];
      reset_fetch_addr <= crf_pkg::RESET_VECTOR_ADDR;
    end
  end

  assign rd_word = s.rd_word;
  assign rd_byte = s.rd_byte;
  assign addr_out = s.addr;
  assign sp_out = s.sp;
  assign pc_out = s.pc;
  assign cc_out = s.cc_out;
  assign branch_taken = s.branch_taken;
endmodule

// [testbench/crf_checker.sv]
// Checker for the core register file: counter, condition code and stack pointer timing.
// Bound to crf_core by the bench; it sees only the core's ports.
module crf_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic pc_load,
  input wire logic [15:0] pc_data,
  input wire logic vector_load,
  input wire logic [15:0] vector_data,
  input wire crf_pkg::crf_ccop_t cc_op,
  input wire logic [7:0] cc_data,
  input wire logic sp_write,
  input wire logic [15:0] sp_data,
  input wire logic [15:0] pc_out,
  input wire logic [15:0] sp_out,
  input wire logic [7:0] cc_out,
  input wire logic irq_masked,
  input wire logic [15:0] reset_fetch_addr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Fetches are whole words, so an odd counter would point inside an instruction.
  a_pc_even: assert property (pc_out[0] == 1'b0)
    else $error("program counter is odd");
  a_pc_take: assert property (pc_load && !vector_load |=>
    pc_out == ($past(pc_data) & 16'hFFFE))
    else $error("program counter load lost");
  a_vector_wins: assert property (vector_load |=>
    pc_out == ($past(vector_data) & 16'hFFFE))
    else $error("vector load did not win");
  a_reset_init: assert property ($fell(rst) |->
    pc_out == 16'h0000 && irq_masked && cc_out == 8'h80)
    else $error("state after reset is wrong");
  a_exc_mask: assert property (cc_op == crf_pkg::CRF_CC_EXC |=> irq_masked)
    else $error("exception start left interrupts open");
  a_cc_load: assert property (cc_op == crf_pkg::CRF_CC_LOAD |->
    ##2 cc_out == $past(cc_data, 2))
    else $error("condition code load not seen");
  a_sp_write: assert property (sp_write |-> ##2 sp_out == $past(sp_data, 2))
    else $error("stack pointer write not seen");
  a_fetch_zero: assert property (reset_fetch_addr == 16'h0000)
    else $error("reset fetch address moved");
  a_mask_mirror: assert property (!$past(rst) |-> cc_out[7] == $past(irq_masked))
    else $error("mask flag and copy disagree");

  // Main scenarios the bench should reach.
  c_load: cover property (cc_op == crf_pkg::CRF_CC_LOAD);
  c_clash: cover property (vector_load && pc_load);
  c_sp: cover property (sp_write);
endmodule

// [testbench/crf_dp_model.sv]
// Datapath model: forms the result that the core's flag logic inspects.
// Combinational; the bench drives its operands in the cycle of the request.
module crf_dp_model (
  input wire crf_pkg::crf_alu_t op,
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  input wire logic [3:0] keep,
  output crf_pkg::crf_areq_t areq
);
  // Add, subtract, compare and negate byte results leave the high byte clear, as a narrow adder would; other byte ops pass a through.
  always_comb
  begin
    areq = '{op: op, a: a, b: b, result: 16'h0000, bit_value: 1'b0, keep: keep};
    case (op)
      crf_pkg::CRF_ALU_ADD_B: areq.result = {8'h00, a[7:0] + b[7:0]};
      crf_pkg::CRF_ALU_SUB_B, crf_pkg::CRF_ALU_CMP_B: areq.result = {8'h00, a[7:0] - b[7:0]};
      crf_pkg::CRF_ALU_NEG_B:
      begin
        // The core expects negate as zero minus b, so the a operand is presented as zero.
        areq.a = 16'h0000;
        areq.result = {8'h00, 8'h00 - b[7:0]};
      end
      crf_pkg::CRF_ALU_ADD_W: areq.result = a + b;
      crf_pkg::CRF_ALU_SUB_W, crf_pkg::CRF_ALU_CMP_W: areq.result = a - b;
      default: areq.result = a;
    endcase
  end
endmodule

// [testbench/cpu_register_file_and_flags_tb.sv]
// Bench for crf_core: drives requests, queues expected values, a monitor compares them.
// Assumes the package, the core, the checker and the datapath model are compiled first.
module cpu_register_file_and_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int due; int sel; logic [15:0] v;} crf_note_t;
  crf_note_t notes[$];
  logic clock = 1'b0, rst = 1'b1, rd_high = 1'b0, sp_write = 1'b0;
  logic pc_load = 1'b0, vector_load = 1'b0, irq_masked, branch_taken, bit_sel;
  logic [2:0] rd_pair = 3'h0, addr_pair = 3'h0, bit_pos = 3'h0;
  logic [15:0] sp_data = 16'h0000, pc_data = 16'h0000, vector_data = 16'h0000;
  logic [15:0] da = 16'h0000, db = 16'h0000, v, u, rd_word, addr_out, sp_out, pc_out;
  logic [15:0] reset_fetch_addr, mem[8], seen[11];
  logic [7:0] cc_data = 8'h00, rd_byte, cc_out, bcd_adjust, ecc;
  logic [3:0] keep = 4'h0;
  crf_pkg::crf_wreq_t wreq = '0;
  crf_pkg::crf_ccop_t cc_op = crf_pkg::CRF_CC_NONE;
  crf_pkg::crf_br_t br_cond = crf_pkg::CRF_BR_ALWAYS;
  crf_pkg::crf_alu_t op = crf_pkg::CRF_ALU_ADD_B;
  crf_pkg::crf_areq_t areq;
  crf_pkg::crf_ccop_t ops[5] = '{crf_pkg::CRF_CC_LOAD, crf_pkg::CRF_CC_AND,
    crf_pkg::CRF_CC_OR, crf_pkg::CRF_CC_XOR, crf_pkg::CRF_CC_EXC};
  crf_pkg::crf_alu_t aops[7] = '{crf_pkg::CRF_ALU_ADD_B, crf_pkg::CRF_ALU_SUB_B,
    crf_pkg::CRF_ALU_CMP_B, crf_pkg::CRF_ALU_NEG_B, crf_pkg::CRF_ALU_ADD_W,
    crf_pkg::CRF_ALU_SUB_W, crf_pkg::CRF_ALU_CMP_W};
  logic [7:0] bin[4] = '{8'h3C, 8'hA2, 8'h12, 8'h7F};
  logic [7:0] bcc[4] = '{8'h80, 8'hA0, 8'h81, 8'hA1};
  logic [7:0] bout[4] = '{8'h06, 8'h66, 8'h60, 8'h9A};
  string nm[11] = '{"rd_word", "rd_byte", "addr_out", "sp_out", "pc_out", "cc_out",
    "irq_masked", "branch_taken", "bit_sel", "bcd_adjust", "reset_fetch_addr"};
  int cyc = 0, n_errors = 0, checked = 0, seed = 32'h260b;

  crf_core DUT (.clock, .rst, .rd_pair, .rd_high, .addr_pair, .wreq, .sp_write, .sp_data,
    .pc_load, .pc_data, .vector_load, .vector_data, .cc_op, .cc_data, .areq, .bit_pos,
    .br_cond, .rd_word, .rd_byte, .addr_out, .sp_out, .pc_out, .cc_out, .irq_masked,
    .branch_taken, .bit_sel, .bcd_adjust, .reset_fetch_addr);
  crf_dp_model dp (.op, .a(da), .b(db), .keep, .areq);

  // A 4 ns clock and a cycle count that dates every expected value.
  always #2 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  // Flags of an add or subtract; word steps carry out of bit 15, half carry out of bit 11.
  function automatic logic [7:0] flags(input logic [7:0] c, input crf_pkg::crf_alu_t o,
    input logic [15:0] x, input logic [15:0] y, input logic [3:0] k);
    logic w, s;
    logic [15:0] m, q;
    logic [16:0] t;
    logic [3:0] f;
    int b;
    w = o inside {crf_pkg::CRF_ALU_ADD_W, crf_pkg::CRF_ALU_SUB_W, crf_pkg::CRF_ALU_CMP_W};
    s = !(o inside {crf_pkg::CRF_ALU_ADD_B, crf_pkg::CRF_ALU_ADD_W});
    b = w ? 15 : 7;
    m = w ? 16'hFFFF : 16'h00FF;
    x = (o == crf_pkg::CRF_ALU_NEG_B) ? 16'h0000 : x & m;
    y = y & m;
    t = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    q = x ^ y ^ t[15:0];
    f = {t[b], (t[15:0] & m) == 16'h0000, (s ^ (x[b] == y[b])) && t[b] != x[b], t[b + 1]};
    return {c[7:6], q[b - 3], c[4], (f & ~k) | (c[3:0] & k)};
  endfunction

  // Branch outcome for every condition code, indexed by the code.
  function automatic logic taken(input logic [3:0] f, input logic [3:0] code);
    logic [15:0] t;
    logic n, z, o, c;
    {n, z, o, c} = f;
    t = {z | (n ^ o), !(z | (n ^ o)), n ^ o, !(n ^ o), n, !n, o, !o, z, !z, c, !c, c | z,
      !(c | z), 1'b0, 1'b1};
    return t[code];
  endfunction

  task automatic note(input int d, input int s, input logic [15:0] x);
    notes.push_back('{cyc + 1 + d, s, x});
  endtask

  // Ends a one-cycle request; only pulses are cleared, levels stay.
  task automatic rest();
    @(posedge clock);
    wreq.width <= crf_pkg::CRF_WR_NONE;
    cc_op <= crf_pkg::CRF_CC_NONE;
    {sp_write, pc_load, vector_load} <= 3'h0;
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compares due notes at the falling edge, once registered outputs have settled.
  always @(negedge clock)
  begin
    seen = '{rd_word, {8'h00, rd_byte}, addr_out, sp_out, pc_out, {8'h00, cc_out},
      {15'h0, irq_masked}, {15'h0, branch_taken}, {15'h0, bit_sel}, {8'h00, bcd_adjust},
      reset_fetch_addr};
    while (notes.size() > 0 && notes[0].due <= cyc)
    begin
      checked++;
      if (seen[notes[0].sel] !== notes[0].v)
      begin
        $display("CHECK FAILED %s expected %h seen %h", nm[notes[0].sel], notes[0].v,
          seen[notes[0].sel]);
        n_errors++;
      end
      void'(notes.pop_front());
    end
  end

  // Main sequence: reset, stack pointer first, pairs, counter, flags, bits, decimal adjust.
  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    ecc = 8'h80;
    note(0, 4, 16'h0000);
    note(0, 6, 16'h0001);
    note(0, 10, 16'h0000);
    @(posedge clock);
    mem[7] = 16'($random(seed)) & 16'hFFFE;
    sp_write <= 1'b1;
    sp_data <= mem[7];
    wreq <= '{crf_pkg::CRF_WR_WORD, 3'h7, ~mem[7]};
    note(2, 3, mem[7]);
    rest();
    // Word write and half write back to back, then read the untouched half.
    for (int p = 0; p < 8; p++)
    begin
      mem[p] = 16'($random(seed));
      @(posedge clock);
      wreq <= '{crf_pkg::CRF_WR_WORD, 3'(p), mem[p]};
      @(posedge clock);
      v = 16'($random(seed));
      wreq <= '{p[0] ? crf_pkg::CRF_WR_HIGH : crf_pkg::CRF_WR_LOW, 3'(p), v};
      if (p[0]) mem[p][15:8] = v[7:0];
      else mem[p][7:0] = v[7:0];
      rest();
      {rd_pair, addr_pair, rd_high} <= {3'(p), 3'(p), !p[0]};
      note(1, 0, mem[p]);
      note(1, 1, {8'h00, p[0] ? mem[p][7:0] : mem[p][15:8]});
      note(1, 2, mem[p]);
    end
    @(posedge clock);
    v = 16'($random(seed)) | 16'h0001;
    pc_load <= 1'b1;
    pc_data <= v;
    note(1, 4, v & 16'hFFFE);
    rest();
    @(posedge clock);
    {pc_load, vector_load} <= 2'h3;
    vector_data <= ~v;
    note(1, 4, ~v & 16'hFFFE);
    rest();
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clock);
      v = 16'($random(seed));
      cc_op <= ops[i % 5];
      cc_data <= v[7:0];
      case (i % 5)
        0: ecc = v[7:0];
        1: ecc = ecc & v[7:0];
        2: ecc = ecc | v[7:0];
        3: ecc = ecc ^ v[7:0];
        default: ecc[7] = 1'b1;
      endcase
      note(1, 6, {15'h0, ecc[7]});
      note(2, 5, {8'h00, ecc});
      rest();
    end
    // Arithmetic flags with every branch code; one step holds its status flags.
    for (int i = 0; i < 48; i++)
    begin
      @(posedge clock);
      v = 16'($random(seed));
      u = 16'($random(seed));
      {da, db, op, keep} <= {v, u, aops[i % 7], (i == 5) ? 4'hF : 4'h0};
      cc_op <= crf_pkg::CRF_CC_ALU;
      br_cond <= crf_pkg::crf_br_t'(i[3:0]);
      ecc = flags(ecc, aops[i % 7], v, u, (i == 5) ? 4'hF : 4'h0);
      note(2, 5, {8'h00, ecc});
      note(2, 7, {15'h0, taken(ecc[3:0], i[3:0])});
      rest();
    end
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      v = 16'($random(seed));
      da <= v;
      bit_pos <= 3'(i);
      note(1, 8, {15'h0, v[i]});
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      cc_op <= crf_pkg::CRF_CC_LOAD;
      cc_data <= bcc[i];
      rest();
      op <= (i == 3) ? crf_pkg::CRF_ALU_DEC_SUB : crf_pkg::CRF_ALU_DEC_ADD;
      da <= {8'h00, bin[i]};
      note(1, 9, {8'h00, bout[i]});
    end
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    note(0, 4, 16'h0000);
    note(0, 6, 16'h0001);
    repeat (4) @(posedge clock);
    if (notes.size() != 0) n_errors++;
    give_verdict();
  end

  // Cuts a hung run short.
  initial
  begin
    repeat (5000) @(posedge clock);
    n_errors++;
    give_verdict();
  end
endmodule

bind crf_core crf_checker chk (.clock, .rst, .pc_load, .pc_data, .vector_load, .vector_data,
  .cc_op, .cc_data, .sp_write, .sp_data, .pc_out, .sp_out, .cc_out, .irq_masked,
  .reset_fetch_addr);
